// [src/crtc_ext_defines.vh]
// Register indices, field positions and reset values for the extended CRT controls.
// Assumes an indexed 8-bit register port: index strobe plus data strobes.
// Function
// [RULE1] Odd field end count sets character count ending odd-field vertical sync.
// [RULE2] Misc bits 7:6 extend vertical blank end to ten bits.
// [RULE3] Misc bits 5:4 extend horizontal blank end to eight bits.
// [RULE4] Extensions honoured only when blanking control or extension enable set.
// [RULE5] Double buffer holds start address until vsync after low byte write.
// [RULE6] Interlace gives sync only in text, sync and data in graphics.
// [RULE7] Software keeps scanline double clear; no interlace in modes 4, 6.
// [RULE8] Interlaced: vertical interrupt only at end of odd field.
// [RULE9] Extension enable activates extensions regardless of blanking control.
// [RULE10] Fast-page bit selects fast-page font fetches instead of random reads.
// [RULE11] Blanking control clear: controller blank drives DAC, border displayable.
// [RULE12] Blanking control set: display enable blanks DAC; overlay pin follows blank.
// [RULE13] Blanking control set: blank registers define overlay window active region.
// [RULE14] Offset extension bit is ninth bit of row offset.
// [RULE15] Start address is 19 bits: bit16 from bit0, 18:17 from 3:2.
// [RULE16] Wrap clear: 16-bit character counter, 64K wrap per map.
// [RULE17] Wrap set: 19-bit counter, wrap at installed memory size.
// [RULE18] Wrap with chain-4: low DRAM bits from extended 17:16, upper from 18:12.
// [RULE19] Wrap with double-word: low DRAM bits from counter bits 15:14.
// [RULE20] Misc bits 3:2 select DAC mode switching and overlay mode; code takes DAC switching from overlay mode bits 2:1.
// [RULE21] Software sets odd field end count near half horizontal total.
// [RULE22] Source bit picks external timing at mode 01, internal window at 10.
// [RULE23] Reserved bits read zero, writes ignored.
`ifndef CRTC_EXT_DEFINES_VH
`define CRTC_EXT_DEFINES_VH
`define IDX_ODD_FIELD_END   8'h19
`define IDX_MISC_TIMING     8'h1a
`define IDX_EXT_DISPLAY     8'h1b
`define IDX_OVERLAY_MODE    8'h1d
`define IDX_ROW_OFFSET      8'h13
`define IDX_UNDERLINE_LOC   8'h14
`define IDX_VBLANK_END      8'h16
`define IDX_HBLANK_END      8'h03
`define IDX_START_HIGH      8'h0c
`define IDX_START_LOW       8'h0d
`define IDX_MAX_SCANLINE    8'h09
`define RST_BYTE            8'h00
`define OVL_MODE_MASK       8'h46
`define MODE_EXT_TIMING     2'h1
`define MODE_INT_WINDOW     2'h2
`define F_INTERLACE         0
`define F_DBUF              1
`define F_WRAP              1
`define F_START16           0
`define F_OFS8              4
`define F_BLANK_CTL         5
`define F_FAST_PAGE         6
`define F_EXT_EN            7
`define F_OVL_SRC           6
`define F_DWORD             6
`define F_SCAN_DBL          7
`define MEM_ADDR_W          19
`define WRAP64K_MASK        19'h0ffff
`endif

// [src/crtc_blank_gen.v]
// Horizontal/vertical blanking comparators with extended end values.
// Assumes character and line counters from the surrounding timing generator.
`timescale 1ns/100ps
`include "crtc_ext_defines.vh"
module crtc_blank_gen (
  input  wire       clk,
  input  wire       rstn,
  input  wire [7:0] char_cnt,
  input  wire [9:0] line_cnt,
  input  wire [7:0] hblank_start,
  input  wire [7:0] hblank_end,
  input  wire [9:0] vblank_start,
  input  wire [9:0] vblank_end,
  output reg        blank_ff
);
  reg       hblank_ff;
  reg       vblank_ff;
  wire      nxt_hblank;
  wire      nxt_vblank;
  // Sticky between start and end matches, like the classic comparator
  assign nxt_hblank = (char_cnt == hblank_start) ? 1'b1 :
                      (char_cnt == hblank_end)   ? 1'b0 : hblank_ff;
  assign nxt_vblank = (line_cnt == vblank_start) ? 1'b1 :
                      (line_cnt == vblank_end)   ? 1'b0 : vblank_ff;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hblank_ff <= 1'b0;
      vblank_ff <= 1'b0;
      blank_ff  <= 1'b0;
    end else begin
      hblank_ff <= nxt_hblank;
      vblank_ff <= nxt_vblank;
      blank_ff  <= nxt_hblank | nxt_vblank;
    end
  end
endmodule

// [src/crtc_addr_map.v]
// Display memory address formation for extended wrap, chain-4 and double-word modes.
// Assumes the host path supplies bus address bits and the selected window offset.
`timescale 1ns/100ps
`include "crtc_ext_defines.vh"
module crtc_addr_map (
  input  wire [18:0] char_addr,
  input  wire        wrap_en,
  input  wire        chain4,
  input  wire        dword,
  input  wire [4:0]  host_bus_address,
  input  wire [6:0]  window_offset,
  output reg  [18:0] extended_memory_address,
  output reg  [8:0]  dram_address
);
  reg [18:0] wrapped;
  reg [6:0]  upper;
  always @* begin
    wrapped = wrap_en ? char_addr : (char_addr & `WRAP64K_MASK); // [RULE16] [RULE17]
    upper   = {2'h0, host_bus_address} + window_offset;          // [RULE18]
    extended_memory_address = {upper, wrapped[11:0]};
    dram_address = wrapped[8:0];
    if (wrap_en && chain4)
      dram_address = {upper, extended_memory_address[17:16]};    // [RULE18]
    else if (wrap_en && dword)
      dram_address = {upper, wrapped[15:14]};                    // [RULE19]
  end
endmodule

// [src/crtc_ext_ctrl.v]
// Extended CRT controller controls: indexed registers, start buffering, interlace,
// blank routing, overlay source and memory address extension.
// Assumes synchronous indexed writes/reads and counters from the base timing.
`timescale 1ns/100ps
`include "crtc_ext_defines.vh"
module crtc_ext_ctrl (
  input  wire        clk,
  input  wire        rstn,
  input  wire [7:0]  reg_index,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_wdata,
  input  wire        graphics_mode,
  input  wire        chain4,
  input  wire        display_enable,
  input  wire        vsync_start,
  input  wire        frame_end,
  input  wire [7:0]  char_cnt,
  input  wire [9:0]  line_cnt,
  input  wire [7:0]  hblank_start,
  input  wire [9:0]  vblank_start,
  input  wire [18:0] char_addr,
  input  wire [4:0]  host_bus_address,
  input  wire [6:0]  window_offset,
  input  wire        external_video_timing_in_n,
  output reg  [7:0]  reg_rdata_ff,
  output reg  [18:0] start_address_ff,
  output reg  [8:0]  row_offset_ff,
  output reg         odd_field_ff,
  output reg         odd_vsync_end_ff,
  output reg         interlace_sync_ff,
  output reg         interlace_data_ff,
  output reg         vert_irq_ff,
  output reg         dac_blank_ff,
  output reg         overlay_window_out_n_ff,
  output reg         overlay_timing_ff,
  output reg  [1:0]  overlay_mode_ff,
  output reg  [1:0]  dac_switch_ff,
  output reg         fast_page_ff,
  output reg  [18:0] extended_memory_address_ff,
  output reg  [8:0]  dram_address_ff
);
  reg  [7:0]  odd_field_end_count_ff;
  reg  [7:0]  misc_timing_control_ff;
  reg  [7:0]  extended_display_control_ff;
  reg  [7:0]  overlay_mode_control_ff;
  reg  [7:0]  row_offset_register_ff;
  reg  [7:0]  underline_location_register_ff;
  reg  [7:0]  vertical_blank_end_register_ff;
  reg  [7:0]  horizontal_blank_end_register_ff;
  reg  [7:0]  max_scanline_control_ff;
  reg  [15:0] start_pend_ff;
  reg         swap_pend_ff;
  reg  [9:0]  last_line_ff;
  wire        ext_on;
  wire [7:0]  hb_end;
  wire [9:0]  vb_end;
  wire        crtc_blank;
  wire [18:0] ema;
  wire [8:0]  dma;
  wire [18:0] nxt_start;
  wire        low_wr;
  wire        is_dbuf;
  assign ext_on = extended_display_control_ff[`F_EXT_EN] |
                  extended_display_control_ff[`F_BLANK_CTL];            // [RULE4] [RULE9]
  assign hb_end = ext_on ? {misc_timing_control_ff[5:4], horizontal_blank_end_register_ff[5:0]}
                         : {2'h0, horizontal_blank_end_register_ff[5:0]}; // [RULE3]
  assign vb_end = ext_on ? {misc_timing_control_ff[7:6], vertical_blank_end_register_ff}
                         : {2'h0, vertical_blank_end_register_ff};       // [RULE2]
  assign low_wr  = reg_wr && (reg_index == `IDX_START_LOW);
  assign is_dbuf = misc_timing_control_ff[`F_DBUF];
  assign nxt_start = {extended_display_control_ff[3:2],
                      extended_display_control_ff[`F_START16], start_pend_ff}; // [RULE15]

  crtc_blank_gen u_blank (
    .clk          (clk),
    .rstn         (rstn),
    .char_cnt     (char_cnt),
    .line_cnt     (line_cnt),
    .hblank_start (hblank_start),
    .hblank_end   (hb_end),
    .vblank_start (vblank_start),
    .vblank_end   (vb_end),
    .blank_ff     (crtc_blank)
  );

  crtc_addr_map u_addr (
    .char_addr               (char_addr),
    .wrap_en                 (extended_display_control_ff[`F_WRAP]),
    .chain4                  (chain4),
    .dword                   (underline_location_register_ff[`F_DWORD]),
    .host_bus_address        (host_bus_address),
    .window_offset           (window_offset),
    .extended_memory_address (ema),
    .dram_address            (dma)
  );

  // Register writes; reserved overlay bits masked off
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      odd_field_end_count_ff           <= `RST_BYTE;
      misc_timing_control_ff           <= `RST_BYTE;
      extended_display_control_ff      <= `RST_BYTE;
      overlay_mode_control_ff          <= `RST_BYTE;
      row_offset_register_ff           <= `RST_BYTE;
      underline_location_register_ff   <= `RST_BYTE;
      vertical_blank_end_register_ff   <= `RST_BYTE;
      horizontal_blank_end_register_ff <= `RST_BYTE;
      max_scanline_control_ff          <= `RST_BYTE;
      start_pend_ff                    <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_index)
        `IDX_ODD_FIELD_END: odd_field_end_count_ff <= reg_wdata;
        `IDX_MISC_TIMING:   misc_timing_control_ff <= reg_wdata;
        `IDX_EXT_DISPLAY:   extended_display_control_ff <= reg_wdata;
        `IDX_OVERLAY_MODE:  overlay_mode_control_ff <= reg_wdata & `OVL_MODE_MASK; // [RULE23]
        `IDX_ROW_OFFSET:    row_offset_register_ff <= reg_wdata;
        `IDX_UNDERLINE_LOC: underline_location_register_ff <= reg_wdata;
        `IDX_VBLANK_END:    vertical_blank_end_register_ff <= reg_wdata;
        `IDX_HBLANK_END:    horizontal_blank_end_register_ff <= reg_wdata;
        `IDX_MAX_SCANLINE:  max_scanline_control_ff <= reg_wdata;
        `IDX_START_HIGH:    start_pend_ff[15:8] <= reg_wdata;
        `IDX_START_LOW:     start_pend_ff[7:0] <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data registered one cycle after the read strobe
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= `RST_BYTE;
    end else if (reg_rd) begin
      case (reg_index)
        `IDX_ODD_FIELD_END: reg_rdata_ff <= odd_field_end_count_ff;
        `IDX_MISC_TIMING:   reg_rdata_ff <= misc_timing_control_ff;
        `IDX_EXT_DISPLAY:   reg_rdata_ff <= extended_display_control_ff;
        `IDX_OVERLAY_MODE:  reg_rdata_ff <= overlay_mode_control_ff;           // [RULE23]
        `IDX_ROW_OFFSET:    reg_rdata_ff <= row_offset_register_ff;
        `IDX_UNDERLINE_LOC: reg_rdata_ff <= underline_location_register_ff;
        `IDX_VBLANK_END:    reg_rdata_ff <= vertical_blank_end_register_ff;
        `IDX_HBLANK_END:    reg_rdata_ff <= horizontal_blank_end_register_ff;
        `IDX_MAX_SCANLINE:  reg_rdata_ff <= max_scanline_control_ff;
        `IDX_START_HIGH:    reg_rdata_ff <= start_pend_ff[15:8];
        `IDX_START_LOW:     reg_rdata_ff <= start_pend_ff[7:0];
        default:            reg_rdata_ff <= `RST_BYTE;
      endcase
    end
  end

  // Start address: direct, or held until the next vsync after a low-byte write
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      swap_pend_ff     <= 1'b0;
      start_address_ff <= 19'h00000;
    end else if (!is_dbuf) begin
      swap_pend_ff     <= 1'b0;
      start_address_ff <= nxt_start;
    end else begin
      if (vsync_start && swap_pend_ff)
        start_address_ff <= nxt_start;                                    // [RULE5]
      // A write landing on the vsync cycle waits for the following vsync
      swap_pend_ff <= low_wr | (swap_pend_ff & ~vsync_start);             // [RULE5]
    end
  end

  // Field tracking, interlace controls and vertical interrupt
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      odd_field_ff      <= 1'b0;
      odd_vsync_end_ff  <= 1'b0;
      interlace_sync_ff <= 1'b0;
      interlace_data_ff <= 1'b0;
      vert_irq_ff       <= 1'b0;
      last_line_ff      <= 10'h000;
    end else begin
      interlace_sync_ff <= misc_timing_control_ff[`F_INTERLACE];          // [RULE6]
      interlace_data_ff <= misc_timing_control_ff[`F_INTERLACE] & graphics_mode; // [RULE6]
      if (frame_end)
        odd_field_ff <= misc_timing_control_ff[`F_INTERLACE] & ~odd_field_ff;
      // Final scanline learned at each field end; first field after reset assumes line 0
      if (frame_end)
        last_line_ff <= line_cnt;
      // Odd field vsync ends at this character of its final scanline
      odd_vsync_end_ff <= odd_field_ff && (line_cnt == last_line_ff) &&
                          (char_cnt == odd_field_end_count_ff);           // [RULE1]
      if (misc_timing_control_ff[`F_INTERLACE])
        vert_irq_ff <= frame_end & odd_field_ff;                          // [RULE8]
      else
        vert_irq_ff <= frame_end;
    end
  end

  // Blank routing, overlay window and address outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_blank_ff               <= 1'b0;
      overlay_window_out_n_ff    <= 1'b1;
      overlay_timing_ff          <= 1'b1;
      overlay_mode_ff            <= 2'h0;
      dac_switch_ff              <= 2'h0;
      fast_page_ff               <= 1'b0;
      row_offset_ff              <= 9'h000;
      extended_memory_address_ff <= 19'h00000;
      dram_address_ff            <= 9'h000;
    end else begin
      if (extended_display_control_ff[`F_BLANK_CTL]) begin
        dac_blank_ff            <= ~display_enable;                       // [RULE12]
        overlay_window_out_n_ff <= crtc_blank;                            // [RULE12] [RULE13]
      end else begin
        dac_blank_ff            <= crtc_blank;                            // [RULE11]
        overlay_window_out_n_ff <= 1'b1;
      end
      overlay_mode_ff <= misc_timing_control_ff[3:2];                     // [RULE20]
      dac_switch_ff   <= overlay_mode_control_ff[2:1];
      if (!overlay_mode_control_ff[`F_OVL_SRC] && misc_timing_control_ff[3:2] == `MODE_EXT_TIMING)
        overlay_timing_ff <= external_video_timing_in_n;                  // [RULE22]
      else if (overlay_mode_control_ff[`F_OVL_SRC] && misc_timing_control_ff[3:2] == `MODE_INT_WINDOW)
        overlay_timing_ff <= extended_display_control_ff[`F_BLANK_CTL] ? crtc_blank : 1'b1; // [RULE22]
      else
        overlay_timing_ff <= 1'b1;
      fast_page_ff  <= extended_display_control_ff[`F_FAST_PAGE];         // [RULE10]
      row_offset_ff <= {extended_display_control_ff[`F_OFS8], row_offset_register_ff}; // [RULE14]
      extended_memory_address_ff <= ema;
      dram_address_ff            <= dma;
    end
  end
endmodule

// [bench/raster_model.sv]
// Far-side raster timing: character and line counters with sync pulses.
// Assumes one clock; totals of 16 chars by 8 lines keep frames short.
`timescale 1ns/100ps
module raster_model (
  input  wire       clk,
  input  wire       rstn,
  output reg  [7:0] hcnt_ff,
  output reg  [9:0] vcnt_ff,
  output wire       display_enable,
  output wire       vsync_start,
  output wire       frame_end
);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hcnt_ff <= 8'h00;
      vcnt_ff <= 10'h000;
    end else begin
      hcnt_ff <= (hcnt_ff == 8'h0f) ? 8'h00 : hcnt_ff + 8'h01;
      if (hcnt_ff == 8'h0f)
        vcnt_ff <= (vcnt_ff == 10'h007) ? 10'h000 : vcnt_ff + 10'h001;
    end
  end
  assign display_enable = (hcnt_ff < 8'h0c) && (vcnt_ff < 10'h006);
  assign vsync_start    = (vcnt_ff == 10'h006) && (hcnt_ff == 8'h00);
  assign frame_end      = (vcnt_ff == 10'h007) && (hcnt_ff == 8'h0f);
endmodule

// [bench/crtc_ext_ctrl_asserts.sv]
// Port-level properties of the extended CRT control block.
// Assumes frame_end pulses are spaced and graphics_mode moves only with interlace off.
`timescale 1ns/100ps
module crtc_ext_ctrl_asserts (
  input wire        clk,
  input wire        rstn,
  input wire [7:0]  reg_index,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire        graphics_mode,
  input wire        vsync_start,
  input wire        frame_end,
  input wire [7:0]  reg_rdata_ff,
  input wire [18:0] start_address_ff,
  input wire [8:0]  row_offset_ff,
  input wire        odd_field_ff,
  input wire        interlace_sync_ff,
  input wire        interlace_data_ff,
  input wire        vert_irq_ff,
  input wire [1:0]  overlay_mode_ff,
  input wire [1:0]  dac_switch_ff,
  input wire        fast_page_ff
);
  reg [2:0] wr_hist_ff;
  reg [2:0] vs_hist_ff;
  // Last three cycles of each cause, so outputs may lag by up to three edges
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_hist_ff <= 3'h0;
      vs_hist_ff <= 3'h0;
    end else begin
      wr_hist_ff <= {wr_hist_ff[1:0], reg_wr};
      vs_hist_ff <= {vs_hist_ff[1:0], vsync_start};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_irq_after_frame: assert property (vert_irq_ff |-> $past(frame_end))
    else $error("irq without frame end");
  a_irq_odd_only: assert property (vert_irq_ff && interlace_sync_ff |-> $past(odd_field_ff))
    else $error("irq on even field");
  a_irq_one_cycle: assert property (vert_irq_ff |=> !vert_irq_ff)
    else $error("irq longer than a cycle");
  a_data_needs_gfx: assert property (interlace_data_ff |-> interlace_sync_ff && $past(graphics_mode))
    else $error("interlaced data outside graphics");
  a_start_cause: assert property ($past(rstn) && $changed(start_address_ff) |-> (wr_hist_ff | vs_hist_ff) != 3'h0)
    else $error("start address moved without cause");
  a_rowofs_cause: assert property ($past(rstn) && $changed(row_offset_ff) |-> wr_hist_ff != 3'h0)
    else $error("row offset moved without write");
  a_ctrl_cause: assert property ($past(rstn) && $changed({overlay_mode_ff, dac_switch_ff, fast_page_ff}) |-> wr_hist_ff != 3'h0)
    else $error("control outputs moved without write");
  a_rd_unmapped: assert property ($past(reg_rd) && $past(reg_index) == 8'h20 |-> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  a_rd_ovl_mask: assert property ($past(reg_rd) && $past(reg_index) == 8'h1d |-> (reg_rdata_ff & 8'hb9) == 8'h00)
    else $error("reserved overlay bits read back");
  cover property (vert_irq_ff && interlace_sync_ff);
  cover property (interlace_data_ff);
  cover property ($changed(start_address_ff) && vs_hist_ff != 3'h0);
endmodule
bind crtc_ext_ctrl crtc_ext_ctrl_asserts crtc_ext_ctrl_asserts_i (.clk(clk), .rstn(rstn),
  .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd), .graphics_mode(graphics_mode),
  .vsync_start(vsync_start), .frame_end(frame_end), .reg_rdata_ff(reg_rdata_ff),
  .start_address_ff(start_address_ff), .row_offset_ff(row_offset_ff), .odd_field_ff(odd_field_ff),
  .interlace_sync_ff(interlace_sync_ff), .interlace_data_ff(interlace_data_ff), .vert_irq_ff(vert_irq_ff),
  .overlay_mode_ff(overlay_mode_ff), .dac_switch_ff(dac_switch_ff), .fast_page_ff(fast_page_ff));

// [bench/crtc_extended_display_controls_test.sv]
// Self-checking bench for the extended CRT controls, with raster model.
// Assumes indexed register strobes and outputs registered as handed over.
`timescale 1ns/100ps
module crtc_extended_display_controls_test;
  logic clk, rstn, reg_wr, reg_rd, graphics_mode, chain4, ext_n, de_q;
  logic [7:0] reg_index, reg_wdata, a, b, c, v, d, rdata;
  logic [18:0] char_addr, start_address_ff, ema;
  logic [4:0] host_bus_address;
  logic [6:0] window_offset, sum;
  logic [31:0] r;
  logic [8:0] row_offset_ff, dram_address_ff;
  logic [7:0] char_cnt;
  logic [9:0] line_cnt;
  logic [1:0] ovl_mode, dac_sw;
  logic de, vs, fe, odd, isync, idata, irq, dblank, otime, fpage, ove, ovw, de_qq;
  integer error_cnt, comparisons, irq_n, m0, i, g;
  raster_model raster_model_i (.clk(clk), .rstn(rstn), .hcnt_ff(char_cnt), .vcnt_ff(line_cnt),
    .display_enable(de), .vsync_start(vs), .frame_end(fe));
  crtc_ext_ctrl crtc_ext_ctrl_i (.clk(clk), .rstn(rstn), .reg_index(reg_index), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .graphics_mode(graphics_mode), .chain4(chain4),
    .display_enable(de), .vsync_start(vs), .frame_end(fe), .char_cnt(char_cnt), .line_cnt(line_cnt),
    .hblank_start(8'h0c), .vblank_start(10'h006), .char_addr(char_addr),
    .host_bus_address(host_bus_address), .window_offset(window_offset),
    .external_video_timing_in_n(ext_n), .reg_rdata_ff(rdata), .start_address_ff(start_address_ff),
    .row_offset_ff(row_offset_ff), .odd_field_ff(odd), .odd_vsync_end_ff(ove), .interlace_sync_ff(isync),
    .interlace_data_ff(idata), .vert_irq_ff(irq), .dac_blank_ff(dblank), .overlay_window_out_n_ff(ovw),
    .overlay_timing_ff(otime), .overlay_mode_ff(ovl_mode), .dac_switch_ff(dac_sw), .fast_page_ff(fpage),
    .extended_memory_address_ff(ema), .dram_address_ff(dram_address_ff));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    de_q <= de;
    de_qq <= de_q;
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end
  function [8:0] dram_exp(input integer m, input [31:0] q);
    logic [6:0] s;
    begin
      s = q[23:19] + q[30:24];
      dram_exp = (m == 0) ? q[8:0] : (m == 1) ? {s, s[5:4]} : {s, q[15:14]};
    end
  endfunction
  task close_out;
    begin
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] ix, input [7:0] dt);
    begin
      @(posedge clk);
      reg_index <= ix;
      reg_wdata <= dt;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] ix);
    begin
      @(posedge clk);
      reg_index <= ix;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task st;
    begin
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  // Waits for frame end (s=0), vsync start (s=1) or odd vsync end (s=2), bounded
  task wait_ev(input integer s);
    integer k;
    begin
      k = 0;
      while ((s == 0 ? fe : s == 1 ? vs : ove) !== 1'b1 && k < 300) begin
        @(posedge clk);
        #1 k = k + 1;
      end
      if (k >= 300) begin
        error_cnt = error_cnt + 1;
        close_out;
      end
    end
  endtask
  task frames(input integer exp);
    begin
      wait_ev(0);
      m0 = irq_n;
      repeat (3) begin
        @(posedge clk);
        #1 wait_ev(0);
      end
      st;
      chk(irq_n - m0, exp);
    end
  endtask
  initial begin
    {reg_wr, reg_rd, graphics_mode, chain4, reg_index, reg_wdata} = 0;
    {char_addr, host_bus_address, window_offset} = 0;
    ext_n = 1'b1;
    rstn = 1'b0;
    irq_n = 0;
    error_cnt = 0;
    comparisons = 0;
    r = $urandom(75819);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 3; i++) begin
      rd(8'h19 + i);
      chk(d, 8'h00);
    end
    for (i = 0; i < 10; i++) begin
      r = $urandom;
      c = (i % 5 == 3) ? 8'h46 : (i % 5 == 4) ? 8'h00 : 8'hff;
      a = (i % 5 == 3) ? 8'h1d : (i % 5 == 4) ? 8'h20 : 8'h19 + i % 5;
      wr(a, r[7:0]);
      rd(a);
      chk(d, r[7:0] & c);
    end
    {a, b, c, v} = $urandom;
    wr(8'h1a, 8'h00);
    wr(8'h1b, v & 8'h1d);
    wr(8'h0c, a);
    wr(8'h0d, b);
    wr(8'h13, c);
    st;
    chk(start_address_ff, {v[3:2], v[0], a, b});
    chk(row_offset_ff, {v[4], c});
    wr(8'h1a, 8'h02);
    wait_ev(0);
    wr(8'h0c, ~a);
    wr(8'h0d, b);
    st;
    chk(start_address_ff, {v[3:2], v[0], a, b});
    wait_ev(1);
    st;
    chk(start_address_ff, {v[3:2], v[0], ~a, b});
    wr(8'h09, 8'h00);
    wr(8'h19, 8'h08);
    for (g = 0; g < 2; g++) begin
      graphics_mode <= g[0];
      wr(8'h1a, 8'h01);
      st;
      chk(isync, 1'b1);
      chk(idata, g[0]);
      frames(2);
      wait_ev(2);
      chk({line_cnt, char_cnt}, {10'h007, 8'h09});
      chk(odd, 1'b1);
      wr(8'h1a, 8'h00);
      st;
    end
    frames(4);
    for (i = 0; i < 4; i++) begin
      ext_n <= $urandom;
      wr(8'h1a, {4'h0, i[1:0], 2'b00});
      wr(8'h1d, {1'b0, i[1], 3'h0, i[1:0], 1'b0});
      wr(8'h1b, {1'b0, i[0], i != 3, 5'h00});
      st;
      chk(ovl_mode, i[1:0]);
      chk(dac_sw, i[1:0]);
      chk(fpage, i[0]);
      if (i != 3) chk(dblank, !de_q);
      else chk(dblank, !de_qq);
      chk(ovw, (i != 3) ? !de_qq : 1'b1);
      chk(otime, (i == 1) ? ext_n : (i == 2) ? !de_qq : 1'b1);
    end
    // Extended horizontal end 0x42 never matches, so blank sticks while honoured
    wr(8'h03, 8'h02);
    wr(8'h1a, 8'h10);
    for (g = 0; g < 2; g++) begin
      wr(8'h1b, g[0] ? 8'h00 : 8'h80);
      wait_ev(0);
      repeat (8) @(posedge clk);
      #1 chk(dblank, !g[0]);
    end
    for (i = 0; i < 9; i++) begin
      r = $urandom;
      char_addr <= r[18:0];
      host_bus_address <= r[23:19];
      window_offset <= r[30:24];
      chain4 <= (i % 3 == 1);
      wr(8'h1b, {6'h0, i % 3 != 0, 1'b0});
      wr(8'h14, {1'b0, i % 3 == 2, 6'h0});
      st;
      sum = r[23:19] + r[30:24];
      chk(dram_address_ff, dram_exp(i % 3, r));
      if (i % 3 != 0) chk(ema[18:12], sum);
      chk(ema[11:0], r[11:0]);
    end
    close_out;
  end
endmodule
